// *** rtl/serial_pkg.sv ***
// Purpose: Shared types and constants of the clocked serial interface
// Assumes: Peripheral clock of 25 MHz, serial clock on its own pin
// Notes:   Status layout is shared by the status port and its write port
package serial_pkg;

  // ==========================================================
  // Control, status and link carriers
  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_end_irq_enable;
    logic ext_clk_sel;
    logic async_mode;
    logic parity_on;
  } serial_ctrl_t;

  typedef struct packed {
    logic tx_buf_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic tx_end_flag;
  } serial_status_t;

  typedef struct packed {
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       rx_on;
  } link_ctrl_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;

  // ==========================================================
  // Field positions and reset values
  localparam int             CHAR_BITS      = 8;
  localparam int             STAT_W         = 6;
  localparam int             POS_TX_BUF_EMPTY_FLAG       = 5;
  localparam int             POS_RX_FULL_FLAG       = 4;
  localparam int             POS_OVR        = 3;
  localparam int             POS_FER        = 2;
  localparam int             POS_PER        = 1;
  localparam int             POS_TX_END_FLAG       = 0;
  localparam serial_status_t STATUS_RESET   = 6'h21;
  localparam logic [7:0]     DATA_RESET     = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;

endpackage

// *** rtl/bit_sync.sv ***
// Purpose: Two flip-flop synchroniser for levels and toggles
// Assumes: Input is stable for more than one destination clock period
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             clk,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d_in;
    q_out    <= meta_reg;
  end

endmodule

// *** rtl/serial_link.sv ***
// Purpose: Shift logic on the serial clock: send on fall, sample on rise
// Assumes: Control word is held stable across serial clock edges
// Notes:   Completion is reported by toggles for the peripheral domain
`timescale 1ns/1ps
module serial_link
  import serial_pkg::*;
(
  // Serial clock and its reset
  input  wire logic       ser_clk,
  input  wire logic       link_rst,
  // Control from the peripheral domain
  input  link_ctrl_t      link_ctrl,
  // Pins
  input  wire logic       rxd,
  output logic            txd,
  // Completion toggles and received word
  output logic            tx_done_tgl,
  output logic            rx_done_tgl,
  output logic [7:0]      rx_word
);

  logic       rst_fall;
  logic       rst_rise;
  logic [2:0] tx_cnt_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;

  bit_sync #(.WIDTH(1)) u_rst_fall (.clk(~ser_clk), .d_in(link_rst), .q_out(rst_fall));
  bit_sync #(.WIDTH(1)) u_rst_rise (.clk(ser_clk), .d_in(link_rst), .q_out(rst_rise));

  // ==========================================================
  // Transmit: one bit per falling edge, LSB first
  always_ff @(negedge ser_clk) begin
    if (rst_fall) begin
      tx_cnt_reg  <= 3'h0;
      txd         <= 1'b1;
      tx_done_tgl <= 1'b0;
    end else if (!link_ctrl.tx_valid) begin
      tx_cnt_reg <= 3'h0;
    end else begin
      txd        <= link_ctrl.tx_data[tx_cnt_reg];
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
      if (tx_cnt_reg == 3'h7) begin
        tx_done_tgl <= ~tx_done_tgl;
      end
    end
  end

  // ==========================================================
  // Receive: sample on each rising edge
  always_ff @(posedge ser_clk) begin
    if (rst_rise) begin
      rx_cnt_reg   <= 3'h0;
      rx_shift_reg <= DATA_RESET;
      rx_word      <= DATA_RESET;
      rx_done_tgl  <= 1'b0;
    end else if (!link_ctrl.rx_on) begin
      rx_cnt_reg <= 3'h0;
    end else begin
      rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
      rx_cnt_reg   <= rx_cnt_reg + 3'h1;
      if (rx_cnt_reg == 3'h7) begin
        rx_word     <= {rxd, rx_shift_reg[7:1]};
        rx_done_tgl <= ~rx_done_tgl;
      end
    end
  end

endmodule

// *** rtl/sync_serial_irq_and_control.sv ***
// Purpose: Control, flags and interrupt requests of a clocked serial interface
// Assumes: Serial clock arrives on ser_clk; in internal mode it is sck_out fed back
// Notes:   Status flags clear by read-as-1 then write-0
// Operation
// - Separate maskable request per interrupt source
// - Buffer empty with enable raises transmit request
// - Transmit end with enable raises end request
// - Receive full with enable raises receive request
// - Any receive error with enable raises error
// - Controller buffer write clears empty flag while transmit is enabled
// - Controller data read clears full flag
// - Empty request wins over end request
// - Empty flag sets on buffer-to-shifter move
// - Buffer writes accepted except in standby, may overwrite
// - Held in standby after reset until released
// - Async break sets framing error, repeatedly
// - Clearing transmit enable resets transmitter at once
// - Receive errors block transmit start in sync
// - Receive disable leaves error flags intact
// - Late external-clock disable: full set, no copy
// - Late internal-clock disable: full set, no copy
// - Eight-bit frames, send on fall, sample rise
// - Character while full sets overrun, keeps data
`timescale 1ns/1ps
module sync_serial_irq_and_control
  import serial_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYC
) (
  // Clocks and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       ser_clk,
  // Serial pins
  input  wire logic       rxd_pin,
  output logic            txd_pin,
  output logic            sck_out,
  output logic            sck_oe,
  // Standby and control
  input  wire logic       module_stop,
  input  serial_ctrl_t    ctrl,
  // Software data access
  input  wire logic       txbuf_wr,
  input  wire logic [7:0] txbuf_data,
  output logic      [7:0] rx_data,
  // Transfer controller access
  input  wire logic       xfer_wr,
  input  wire logic [7:0] xfer_data,
  input  wire logic       xfer_rd,
  output logic            xfer_tx_start,
  output logic            xfer_rx_start,
  // Status access
  input  wire logic       status_rd,
  input  wire logic       status_wr,
  input  serial_status_t  status_wdata,
  output serial_status_t  status,
  output logic            standby,
  output logic            tx_busy,
  // Interrupt requests
  output logic            tx_empty_irq,
  output logic            tx_end_irq,
  output logic            rx_full_irq,
  output logic            rx_error_irq
);

  // ==========================================================
  // Declarations
  serial_status_t flags_reg;
  logic [STAT_W-1:0] read_seen_reg;
  logic [STAT_W-1:0] sw_clr;
  serial_ctrl_t   ctrl_eff;
  tx_state_t      tx_state_reg;
  logic [7:0]     tx_buffer_reg;
  logic [7:0]     tx_shift_reg;
  logic [7:0]     rx_buffer_reg;
  logic           tx_seen_reg;
  logic           standby_reg;
  link_ctrl_t     link_ctrl;
  logic           link_txd;
  logic           link_tx_tgl;
  logic           link_rx_tgl;
  logic [7:0]     link_rx_word;
  logic [1:0]     tgl_sync;
  logic [1:0]     tgl_prev_reg;
  logic           tx_done_ev;
  logic           rx_done_ev;
  logic           err_any;
  logic           tx_block;
  logic           buf_write;
  logic [7:0]     buf_wdata;
  logic           tx_load;
  logic           tx_finish;
  logic           rx_on;
  logic [3:0]     pulses_reg;
  logic [15:0]    div_reg;
  logic           sck_reg;
  logic           sck_run;

  // Clear request for one flag: written 0 after being seen as 1
  function automatic logic clr_bit(input logic wr, input logic wbit, input logic seen);
    clr_bit = wr & ~wbit & seen;
  endfunction

  // ==========================================================
  // Standby: held stopped from reset until released
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= module_stop;
    end
  end

  assign standby  = standby_reg;
  assign ctrl_eff = standby_reg ? '0 : ctrl;

  // ==========================================================
  // Crossing of completion toggles from the serial clock
  bit_sync #(.WIDTH(2)) u_tgl_sync (
    .clk   (ref_clk),
    .d_in  ({link_tx_tgl, link_rx_tgl}),
    .q_out (tgl_sync)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tgl_prev_reg <= 2'h0;
    end else begin
      tgl_prev_reg <= tgl_sync;
    end
  end

  assign tx_done_ev = (tgl_sync[1] ^ tgl_prev_reg[1]) & ~standby_reg;
  assign rx_done_ev = (tgl_sync[0] ^ tgl_prev_reg[0]) & ~standby_reg;

  // ==========================================================
  // Shared conditions
  assign err_any   = flags_reg.overrun_flag | flags_reg.framing_err_flag
                   | flags_reg.parity_err_flag;
  assign tx_block  = err_any & ~ctrl_eff.async_mode;
  assign buf_write = (txbuf_wr | xfer_wr) & ~standby_reg;
  assign buf_wdata = xfer_wr ? xfer_data : txbuf_data;
  assign rx_on     = ctrl_eff.rx_enable_bit & ~err_any;

  assign tx_load = ctrl_eff.tx_enable_bit & ~flags_reg.tx_buf_empty_flag & ~tx_block
                 & ((tx_state_reg == TX_IDLE) | tx_done_ev);
  assign tx_finish = ctrl_eff.tx_enable_bit & (tx_state_reg == TX_SEND)
                   & tx_done_ev & ~tx_load;

  // ==========================================================
  // Transmit buffer: every write outside standby is taken, unsent data is replaced
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_buffer_reg <= DATA_RESET;
    end else if (buf_write) begin
      tx_buffer_reg <= buf_wdata;
    end
  end

  // ==========================================================
  // Transmit sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= DATA_RESET;
      tx_seen_reg  <= 1'b0;
    end else if (!ctrl_eff.tx_enable_bit) begin
      tx_state_reg <= TX_IDLE;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_load) begin
            tx_shift_reg <= tx_buffer_reg;
            tx_state_reg <= TX_SEND;
            tx_seen_reg  <= 1'b1;
          end
        end
        TX_SEND: begin
          if (tx_load) begin
            tx_shift_reg <= tx_buffer_reg;
          end else if (tx_done_ev) begin
            tx_state_reg <= TX_IDLE;
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  assign tx_busy = (tx_state_reg == TX_SEND);

  // ==========================================================
  // Read tracking for the flag clear protocol
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      read_seen_reg <= '0;
    end else if (status_wr) begin
      read_seen_reg <= '0;
    end else if (status_rd) begin
      read_seen_reg <= read_seen_reg | flags_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < STAT_W; i++) begin
      sw_clr[i] = clr_bit(status_wr & ~standby_reg, status_wdata[i], read_seen_reg[i]);
    end
  end

  // ==========================================================
  // Transmit flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.tx_buf_empty_flag <= STATUS_RESET[POS_TX_BUF_EMPTY_FLAG];
    end else if (!ctrl_eff.tx_enable_bit && !standby_reg) begin
      flags_reg.tx_buf_empty_flag <= 1'b1;
    end else if (buf_write) begin
      flags_reg.tx_buf_empty_flag <= 1'b0;
    end else if (tx_load) begin
      flags_reg.tx_buf_empty_flag <= 1'b1;
    end else if (sw_clr[POS_TX_BUF_EMPTY_FLAG]) begin
      flags_reg.tx_buf_empty_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.tx_end_flag <= STATUS_RESET[POS_TX_END_FLAG];
    end else if (!ctrl_eff.tx_enable_bit && !standby_reg) begin
      flags_reg.tx_end_flag <= 1'b1;
    end else if (tx_finish) begin
      flags_reg.tx_end_flag <= 1'b1;
    end else if (tx_load) begin
      flags_reg.tx_end_flag <= 1'b0;
    end else if (sw_clr[POS_TX_END_FLAG]) begin
      flags_reg.tx_end_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Receive completion: full flag, overrun and data copy
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.rx_full_flag <= STATUS_RESET[POS_RX_FULL_FLAG];
    end else if (rx_done_ev && !flags_reg.rx_full_flag) begin
      flags_reg.rx_full_flag <= 1'b1;
    end else if ((xfer_rd && !standby_reg) || sw_clr[POS_RX_FULL_FLAG]) begin
      flags_reg.rx_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.overrun_flag <= STATUS_RESET[POS_OVR];
    end else if (rx_done_ev && flags_reg.rx_full_flag) begin
      flags_reg.overrun_flag <= 1'b1;
    end else if (sw_clr[POS_OVR]) begin
      flags_reg.overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_buffer_reg <= DATA_RESET;
    end else if (rx_done_ev && !flags_reg.rx_full_flag && ctrl_eff.rx_enable_bit) begin
      rx_buffer_reg <= link_rx_word;
    end
  end

  assign rx_data = rx_buffer_reg;

  // ==========================================================
  // Break detection in asynchronous mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.framing_err_flag <= STATUS_RESET[POS_FER];
    end else if (rx_done_ev && ctrl_eff.async_mode && link_rx_word == 8'h00) begin
      flags_reg.framing_err_flag <= 1'b1;
    end else if (sw_clr[POS_FER]) begin
      flags_reg.framing_err_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_reg.parity_err_flag <= STATUS_RESET[POS_PER];
    end else if (rx_done_ev && ctrl_eff.async_mode && ctrl_eff.parity_on
                 && link_rx_word == 8'h00) begin
      flags_reg.parity_err_flag <= 1'b1;
    end else if (sw_clr[POS_PER]) begin
      flags_reg.parity_err_flag <= 1'b0;
    end
  end

  assign status = flags_reg;

  // ==========================================================
  // Interrupt requests and controller start
  assign tx_empty_irq = flags_reg.tx_buf_empty_flag & ctrl_eff.tx_irq_enable;
  assign tx_end_irq   = flags_reg.tx_end_flag & ctrl_eff.tx_end_irq_enable
                      & ~tx_empty_irq;
  assign rx_full_irq  = flags_reg.rx_full_flag & ctrl_eff.rx_irq_enable;
  assign rx_error_irq = err_any & ctrl_eff.rx_irq_enable;

  // Only the data requests may start the transfer controller
  assign xfer_tx_start = tx_empty_irq;
  assign xfer_rx_start = rx_full_irq;

  // ==========================================================
  // Internal serial clock: eight pulses per frame, idle high
  assign sck_run = !ctrl_eff.ext_clk_sel
                 && ((pulses_reg != 4'h0) || (rx_on && tx_state_reg == TX_IDLE));

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !sck_run) begin
      div_reg <= 16'h0000;
    end else if (div_reg == 16'(SCK_HALF - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !sck_run) begin
      sck_reg <= 1'b1;
    end else if (div_reg == 16'(SCK_HALF - 1)) begin
      sck_reg <= ~sck_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !ctrl_eff.tx_enable_bit || ctrl_eff.ext_clk_sel) begin
      pulses_reg <= 4'h0;
    end else begin
      case ({tx_load, sck_run && sck_reg && div_reg == 16'(SCK_HALF - 1)})
        2'b10: pulses_reg   <= pulses_reg + 4'h8;
        2'b11: pulses_reg   <= pulses_reg + 4'h7;
        2'b01: pulses_reg   <= (pulses_reg == 4'h0) ? 4'h0 : pulses_reg - 4'h1;
        default: pulses_reg <= pulses_reg;
      endcase
    end
  end

  assign sck_out = sck_reg;
  assign sck_oe  = ~ctrl_eff.ext_clk_sel & ~standby_reg;

  // ==========================================================
  // Serial clock domain
  assign link_ctrl.tx_valid = tx_busy;
  assign link_ctrl.tx_data  = tx_shift_reg;
  assign link_ctrl.rx_on    = rx_on;

  serial_link u_link (
    .ser_clk     (ser_clk),
    .link_rst    (sys_rst),
    .link_ctrl   (link_ctrl),
    .rxd         (rxd_pin),
    .txd         (link_txd),
    .tx_done_tgl (link_tx_tgl),
    .rx_done_tgl (link_rx_tgl),
    .rx_word     (link_rx_word)
  );

  // Line rests high until the first frame has been started
  assign txd_pin = tx_seen_reg ? link_txd : 1'b1;

endmodule

// *** bench/serial_assertions.sv ***
// Purpose: Port-level checks of flags, requests and standby
// Assumes: Single ref_clk domain, sync active-high reset
// Notes:   Bound to the top module from the bench
`timescale 1ns/1ps
module serial_assertions
  import serial_pkg::*;
(
  // Clock and reset
  input wire logic      ref_clk,
  input wire logic      sys_rst,
  // Inputs
  input wire logic      module_stop,
  input serial_ctrl_t   ctrl,
  input wire logic      txbuf_wr,
  input wire logic      xfer_wr,
  input wire logic      xfer_rd,
  input wire logic      status_wr,
  input serial_status_t status_wdata,
  // Outputs
  input serial_status_t status,
  input logic           standby,
  input logic           tx_busy,
  input logic           tx_empty_irq,
  input logic           tx_end_irq,
  input logic           rx_full_irq,
  input logic           rx_error_irq
);
  // ==========================================================
  // Helpers
  logic rx_err;
  assign rx_err = status.overrun_flag | status.framing_err_flag | status.parity_err_flag;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Requests
  a_tx_irq_map:
    assert property (tx_empty_irq == (status.tx_buf_empty_flag && ctrl.tx_irq_enable
      && !standby)) else $error("tx empty request mismatch");
  a_end_irq_prio:
    assert property (tx_end_irq == (status.tx_end_flag && ctrl.tx_end_irq_enable
      && !standby && !tx_empty_irq)) else $error("tx end request mismatch");
  a_rx_irq_map:
    assert property (rx_full_irq == (status.rx_full_flag && ctrl.rx_irq_enable
      && !standby)) else $error("rx full request mismatch");
  a_err_irq_map:
    assert property (rx_error_irq == (rx_err && ctrl.rx_irq_enable && !standby))
      else $error("rx error request mismatch");

  // ==========================================================
  // Flags and sequencing
  a_xwr_clear:
    assert property (xfer_wr && !standby |=> !status.tx_buf_empty_flag)
      else $error("controller write left empty flag");
  a_xrd_clear:
    assert property (xfer_rd && !standby |=> !status.rx_full_flag)
      else $error("controller read left full flag");
  a_stop_follow:
    assert property (!$past(sys_rst) |-> standby == $past(module_stop))
      else $error("standby does not follow stop request");
  a_load_sets_empty:
    assert property ($rose(tx_busy) |-> status.tx_buf_empty_flag && !status.tx_end_flag)
      else $error("empty flag not set on load");
  a_tx_off_reset:
    assert property (!ctrl.tx_enable_bit && !txbuf_wr && !xfer_wr |=> !tx_busy
      && status.tx_buf_empty_flag && status.tx_end_flag)
      else $error("transmitter not reset");
  a_err_blocks_tx:
    assert property (rx_err && !ctrl.async_mode && !tx_busy |=> !tx_busy)
      else $error("transmit started with error flag");
  a_ones_keep:
    assert property (status_wr && status_wdata == 6'h3F && !xfer_rd && !ctrl.tx_enable_bit
      && !txbuf_wr && !xfer_wr |=> (status & $past(status)) == $past(status))
      else $error("writing ones cleared a flag");
endmodule

// *** bench/serial_peer.sv ***
// Purpose: External synchronous peer that owns the serial clock
// Assumes: 160 ns serial clock, idle high between frames
// Notes:   Data line is inverted once the frame is over
`timescale 1ns/1ps
module serial_peer (
  // Link pins
  output logic      ser_clk,
  output logic      rxd,
  input  wire logic txd
);
  initial begin
    ser_clk = 1'b1;
    rxd     = 1'b1;
  end

  // Free clocks, used only around reset while the link is idle
  task spin(input int n);
    repeat (n) begin
      #80 ser_clk = 1'b0;
      #80 ser_clk = 1'b1;
    end
  endtask

  // One eight-bit frame, LSB first, both directions
  task frame(input logic [7:0] tx, output logic [7:0] rx);
    #13;
    for (int i = 0; i < 8; i++) begin
      #80 ser_clk = 1'b0;
      rxd = tx[i];
      #80 ser_clk = 1'b1;
      rx[i] = txd;
    end
    #80 rxd = ~rxd;
  endtask
endmodule

// *** bench/tb.sv ***
// Purpose: Self-checking bench of the serial control block
// Assumes: External serial clock from the peer model
// Notes:   Reset spans four serial clocks so the link resets too
`timescale 1ns/1ps
module tb;
  import serial_pkg::*;
  logic           ref_clk, sys_rst, ser_clk, rxd_pin, txd_pin, module_stop;
  serial_ctrl_t   ctrl;
  logic           txbuf_wr, xfer_wr, xfer_rd, status_rd, status_wr;
  logic [7:0]     txbuf_data, xfer_data, rx_data, got;
  serial_status_t status_wdata, status;
  logic           standby, tx_busy, tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
  logic           sck_out, sck_oe, xfer_tx_start, xfer_rx_start;
  int             failures, n_compared;

  sync_serial_irq_and_control i_dut (
    .ref_clk, .sys_rst, .ser_clk, .rxd_pin, .txd_pin, .sck_out, .sck_oe,
    .module_stop, .ctrl, .txbuf_wr, .txbuf_data, .rx_data, .xfer_wr, .xfer_data,
    .xfer_rd, .xfer_tx_start, .xfer_rx_start, .status_rd, .status_wr,
    .status_wdata, .status, .standby, .tx_busy, .tx_empty_irq, .tx_end_irq,
    .rx_full_irq, .rx_error_irq
  );
  serial_peer i_peer (.ser_clk, .rxd(rxd_pin), .txd(txd_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Tasks
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wflag(input int b);
    int k;
    k = 0;
    cyc(1);
    while (status[b] !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    chk("flag", 8'(status[b]), 8'h01);
    if (k >= 300) conclude();
  endtask
  task wr(input logic [7:0] d);
    txbuf_data = d;
    txbuf_wr = 1'b1;
    cyc(1);
    txbuf_wr = 1'b0;
  endtask
  task pulse_st(input logic rd, input serial_status_t wd);
    status_rd = rd;
    status_wr = !rd;
    status_wdata = wd;
    cyc(1);
    status_rd = 1'b0;
    status_wr = 1'b0;
    cyc(1);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    {sys_rst, module_stop} = 2'b11;
    ctrl = 8'h00;
    {txbuf_wr, xfer_wr, xfer_rd, status_rd, status_wr} = 5'h00;
    {txbuf_data, xfer_data} = 16'h0000;
    status_wdata = 6'h00;
    failures = 0;
    n_compared = 0;
    i_peer.spin(4);
    cyc(1);
    sys_rst = 1'b0;
    // Idle serial clocks let the link see the reset release before any frame
    i_peer.spin(3);
    cyc(1);
    chk("status", {2'b00, status}, {2'b00, STATUS_RESET});
    chk("txd", 8'(txd_pin), 8'h01);
    chk("sck idle", {6'h00, sck_oe, sck_out}, 8'h01);
    wr(8'h44);
    cyc(1);
    chk("standby write", {2'b00, status}, {2'b00, STATUS_RESET});
    module_stop = 1'b0;
    cyc(2);
    chk("standby", 8'(standby), 8'h00);
    ctrl = 8'hFC;
    cyc(1);
    wr(8'hA5);
    chk("empty", 8'(status[POS_TX_BUF_EMPTY_FLAG]), 8'h00);
    cyc(1);
    chk("loaded", {5'h00, tx_busy, status[POS_TX_BUF_EMPTY_FLAG], tx_empty_irq}, 8'h07);
    chk("tx start", 8'(xfer_tx_start), 8'h01);
    cyc(8);
    i_peer.frame(8'h3C, got);
    chk("tx frame", got, 8'hA5);
    wflag(POS_RX_FULL_FLAG);
    chk("rx data", rx_data, 8'h3C);
    chk("rx irq", 8'(rx_full_irq), 8'h01);
    chk("rx start", 8'(xfer_rx_start), 8'h01);
    wflag(POS_TX_END_FLAG);
    chk("end irq", 8'(tx_end_irq), 8'h00);
    ctrl.tx_irq_enable = 1'b0;
    cyc(1);
    chk("irqs", {6'h00, tx_empty_irq, tx_end_irq}, 8'h01);
    xfer_rd = 1'b1;
    cyc(1);
    xfer_rd = 1'b0;
    chk("full", 8'(status[POS_RX_FULL_FLAG]), 8'h00);
    xfer_data = 8'h5A;
    xfer_wr = 1'b1;
    cyc(1);
    xfer_wr = 1'b0;
    chk("xfer empty", 8'(status[POS_TX_BUF_EMPTY_FLAG]), 8'h00);
    cyc(8);
    i_peer.frame(8'hC3, got);
    chk("xfer frame", got, 8'h5A);
    wflag(POS_RX_FULL_FLAG);
    cyc(6);
    i_peer.frame(8'h77, got);
    wflag(POS_OVR);
    chk("kept data", rx_data, 8'hC3);
    chk("err irq", 8'(rx_error_irq), 8'h01);
    wr(8'h11);
    cyc(4);
    chk("blocked", {6'h00, tx_busy, status[POS_TX_BUF_EMPTY_FLAG]}, 8'h00);
    ctrl.rx_enable_bit = 1'b0;
    cyc(2);
    chk("ovr kept", 8'(status[POS_OVR]), 8'h01);
    pulse_st(1'b0, 6'h00);
    cyc(1);
    chk("no read", 8'(status[POS_OVR]), 8'h01);
    ctrl.tx_enable_bit = 1'b0;
    cyc(1);
    pulse_st(1'b0, 6'h3F);
    pulse_st(1'b1, 6'h00);
    pulse_st(1'b0, 6'h21);
    cyc(1);
    chk("cleared", {2'b00, status}, 8'h21);
    ctrl = 8'hC4;
    cyc(1);
    wr(8'h99);
    cyc(1);
    chk("busy", 8'(tx_busy), 8'h01);
    ctrl.tx_enable_bit = 1'b0;
    cyc(1);
    chk("tx reset", {6'h00, tx_busy, status[POS_TX_END_FLAG]}, 8'h01);
    ctrl = 8'h40;
    cyc(2);
    chk("sck run", {6'h00, sck_oe, sck_out}, 8'h02);
    ctrl = 8'h46;
    cyc(6);
    i_peer.frame(8'h00, got);
    wflag(POS_FER);
    conclude();
  end
endmodule

bind sync_serial_irq_and_control serial_assertions i_chk (
  .ref_clk, .sys_rst, .module_stop, .ctrl, .txbuf_wr, .xfer_wr, .xfer_rd,
  .status_wr, .status_wdata, .status, .standby, .tx_busy, .tx_empty_irq,
  .tx_end_irq, .rx_full_irq, .rx_error_irq
);
